// File: inc/mcasl_pkg.sv
package mcasl_pkg;
  // sample and channel shape
  localparam int unsigned MCASL_NUM_CH = 4;
  localparam int unsigned MCASL_SAMPLE_W = 24;
  localparam int unsigned MCASL_GAIN_W = 3;
  localparam int unsigned MCASL_PHASE_W = 10;
  localparam int unsigned MCASL_CAL_W = 24;
  localparam int unsigned MCASL_CRC_W = 16;
  // modulator clock division
  localparam int unsigned MCASL_CLK_DIV = 2;
  // crc-ccitt polynomial and seed
  localparam logic [15:0] MCASL_CRC_POLY = 16'h1021;
  localparam logic [15:0] MCASL_CRC_SEED = 16'hFFFF;
  // reset values
  localparam logic [2:0] MCASL_GAIN_RST = 3'h0;
  localparam logic [23:0] MCASL_GAIN_CAL_ONE = 24'h800000;
  localparam logic [23:0] MCASL_ZERO24 = 24'h000000;
  localparam logic [9:0] MCASL_PHASE_RST = 10'h000;
  // transfer word index width
  localparam int unsigned MCASL_IDX_W = 3;
  // output word states, gray along the usual path
  typedef enum logic [1:0]
  {
    MCASL_IDLE = 2'b00,
    MCASL_SEND = 2'b01,
    MCASL_CRC = 2'b11
  } mcasl_state_t;
endpackage : mcasl_pkg

// File: src/mcasl_core.sv
// Contract
// - modulator clock is input clock halved
// - sample_ready_n low when new set ready
// - four simultaneous channels, 24-bit each
// - each channel holds its own settings
// - per-channel gain from 1 to 128
// - per-channel phase, offset, gain calibration
// - independent crc enables: in, out, map
`timescale 1ns/100ps
`default_nettype none
module mcasl_core
  import mcasl_pkg::*;
#(
  parameter int unsigned NUM_CH = MCASL_NUM_CH,
  parameter int unsigned SAMPLE_W = MCASL_SAMPLE_W
)
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // modulator side: one new simultaneous set per strobe taken while idle; strobes during a frame are ignored
  input wire logic conv_done_i,
  input wire logic [NUM_CH*SAMPLE_W-1:0] raw_samples_i,
  output logic mod_clk_o,
  // per-channel configuration write port
  input wire logic cfg_we_i,
  input wire logic [1:0] cfg_ch_i,
  input wire logic [MCASL_GAIN_W-1:0] cfg_gain_i,
  input wire logic [MCASL_PHASE_W-1:0] cfg_phase_i,
  input wire logic [MCASL_CAL_W-1:0] cfg_offset_i,
  input wire logic [MCASL_CAL_W-1:0] cfg_gain_cal_i,
  // crc enables and input-word check
  input wire logic crc_in_en_i,
  input wire logic crc_out_en_i,
  input wire logic crc_map_en_i,
  input wire logic [MCASL_CRC_W-1:0] cfg_crc_i,
  output logic cfg_crc_err_o,
  output logic [MCASL_CRC_W-1:0] map_crc_o,
  // per-channel settings readback
  output logic [NUM_CH*MCASL_GAIN_W-1:0] gain_sel_o,
  output logic [NUM_CH*MCASL_PHASE_W-1:0] phase_o,
  // sample word stream toward the host port
  output logic sample_ready_n,
  output logic word_valid_o,
  output logic [SAMPLE_W-1:0] word_data_o,
  output logic word_last_o,
  input wire logic word_ready_i
);
  initial
  begin
    if (NUM_CH != 4 || SAMPLE_W != 24)
      $error("mcasl_core: only four 24-bit channels are served");
  end

  // crc-ccitt over a 24-bit word
  function automatic logic [15:0] crc24(input logic [15:0] c,
                                        input logic [23:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 23; i >= 0; i--)
      r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? MCASL_CRC_POLY : 16'h0000);
    return r;
  endfunction : crc24

  // calibrate: offset add, gain scale by q1.23, saturate to 24 bits
  function automatic logic [23:0] calib(input logic [23:0] x,
                                        input logic [23:0] off,
                                        input logic [23:0] g);
    logic signed [24:0] s;
    logic signed [49:0] p;
    logic signed [26:0] q;
    s = 25'($signed(x)) + 25'($signed(off));
    p = 50'(s) * 50'($signed({1'b0, g}));
    q = p[49:23];
    if (q > 27'sd8388607)
      return 24'h7FFFFF;
    else if (q < -27'sd8388608)
      return 24'h800000;
    else
      return q[23:0];
  endfunction : calib

  // modulator clock divider
  logic mod_clk_q;
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
      mod_clk_q <= 1'b0;
    else
      mod_clk_q <= ~mod_clk_q;
  end
  assign mod_clk_o = mod_clk_q;

  // per-channel configuration storage
  logic [MCASL_GAIN_W-1:0] gain_q [NUM_CH];
  logic [MCASL_PHASE_W-1:0] phase_q [NUM_CH];
  logic [MCASL_CAL_W-1:0] off_q [NUM_CH], gcal_q [NUM_CH];
  logic cfg_ok;
  assign cfg_ok = !crc_in_en_i ||
    (crc24(crc24(MCASL_CRC_SEED, cfg_offset_i), cfg_gain_cal_i)
     == cfg_crc_i);
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        gain_q[c] <= MCASL_GAIN_RST;
        phase_q[c] <= MCASL_PHASE_RST;
        off_q[c] <= MCASL_ZERO24;
        gcal_q[c] <= MCASL_GAIN_CAL_ONE;
      end
    end
    else if (cfg_we_i && cfg_ok)
    begin
      gain_q[cfg_ch_i] <= cfg_gain_i;
      phase_q[cfg_ch_i] <= cfg_phase_i;
      off_q[cfg_ch_i] <= cfg_offset_i;
      gcal_q[cfg_ch_i] <= cfg_gain_cal_i;
    end
  end

  // rejected configuration write flag
  logic cfg_err_q;
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
      cfg_err_q <= 1'b0;
    else if (cfg_we_i)
      cfg_err_q <= !cfg_ok;
  end
  assign cfg_crc_err_o = cfg_err_q;

  // register map crc over the offset words, the upper half of gain word 0 and the lower half of gain word 3
  logic [15:0] map_crc_q;
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
      map_crc_q <= MCASL_CRC_SEED;
    else if (!crc_map_en_i)
      map_crc_q <= MCASL_CRC_SEED;
    else
      map_crc_q <= crc24(crc24(crc24(crc24(MCASL_CRC_SEED, off_q[0]),
        off_q[1]), crc24(crc24(MCASL_CRC_SEED, off_q[2]), off_q[3])),
        {gcal_q[0][23:12], gcal_q[3][11:0]});
  end
  assign map_crc_o = map_crc_q;

  // settings readback
  always_comb
  begin
    for (int c = 0; c < NUM_CH; c++)
    begin
      gain_sel_o[c*MCASL_GAIN_W +: MCASL_GAIN_W] = gain_q[c];
      phase_o[c*MCASL_PHASE_W +: MCASL_PHASE_W] = phase_q[c];
    end
  end

  // capture a simultaneous calibrated set
  logic [SAMPLE_W-1:0] set_q [NUM_CH];
  logic load, ready_q;
  mcasl_state_t state_q;
  assign load = conv_done_i && state_q == MCASL_IDLE;
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      for (int c = 0; c < NUM_CH; c++)
        set_q[c] <= MCASL_ZERO24;
    end
    else if (load)
    begin
      for (int c = 0; c < NUM_CH; c++)
        set_q[c] <= calib(raw_samples_i[c*SAMPLE_W +: SAMPLE_W],
                          off_q[c], gcal_q[c]);
    end
  end

  // two-entry output buffer
  logic [SAMPLE_W-1:0] buf_d_q [2];
  logic buf_l_q [2];
  logic wr_ptr_q, rd_ptr_q, nidx;
  logic [1:0] cnt_q;
  logic push, pop, buf_ready, push_last;
  logic [SAMPLE_W-1:0] push_data;
  assign nidx = pop ? ~rd_ptr_q : rd_ptr_q; // head entry after this edge
  assign buf_ready = cnt_q != 2'h2;
  assign pop = word_valid_o && word_ready_i;
  assign word_valid_o = cnt_q != 2'h0;
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      cnt_q <= 2'h0;
      buf_d_q[0] <= MCASL_ZERO24;
      buf_d_q[1] <= MCASL_ZERO24;
      buf_l_q[0] <= 1'b0;
      buf_l_q[1] <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        buf_d_q[wr_ptr_q] <= push_data;
        buf_l_q[wr_ptr_q] <= push_last;
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop)
        rd_ptr_q <= ~rd_ptr_q;
      cnt_q <= cnt_q + 2'(push) - 2'(pop);
    end
  end
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      word_data_o <= MCASL_ZERO24;
      word_last_o <= 1'b0;
    end
    else
    begin
      word_data_o <= (push && wr_ptr_q == nidx) ? push_data : buf_d_q[nidx];
      word_last_o <= (push && wr_ptr_q == nidx) ? push_last : buf_l_q[nidx];
    end
  end

  // word sequencer: four samples then optional crc word
  logic [MCASL_IDX_W-1:0] idx_q;
  logic [15:0] out_crc_q;
  assign push = buf_ready && state_q != MCASL_IDLE;
  always_comb
  begin
    push_data = set_q[idx_q[1:0]];
    push_last = !crc_out_en_i && idx_q == MCASL_IDX_W'(NUM_CH - 1);
    if (state_q == MCASL_CRC)
    begin
      push_data = {8'h00, out_crc_q};
      push_last = 1'b1;
    end
  end
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_q <= MCASL_IDLE;
      idx_q <= '0;
      out_crc_q <= MCASL_CRC_SEED;
    end
    else
    begin
      case (state_q)
        MCASL_IDLE:
        begin
          idx_q <= '0;
          out_crc_q <= MCASL_CRC_SEED;
          if (conv_done_i)
            state_q <= MCASL_SEND;
        end
        MCASL_SEND:
        begin
          if (push)
          begin
            out_crc_q <= crc24(out_crc_q, push_data);
            idx_q <= idx_q + 1'b1;
            if (idx_q == MCASL_IDX_W'(NUM_CH - 1))
              state_q <= crc_out_en_i ? MCASL_CRC : MCASL_IDLE;
          end
        end
        MCASL_CRC:
        begin
          if (push)
            state_q <= MCASL_IDLE;
        end
        default:
          state_q <= MCASL_IDLE;
      endcase
    end
  end

  // ready flag: set on new set, cleared when last word leaves
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
      ready_q <= 1'b0;
    else if (load)
      ready_q <= 1'b1;
    else if (pop && word_last_o)
      ready_q <= 1'b0;
  end
  assign sample_ready_n = ~ready_q;
endmodule : mcasl_core
`default_nettype wire

// File: verification/mcasl_core_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module mcasl_chk
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // watched ports
  input wire logic conv_done_i,
  input wire logic mod_clk_o,
  input wire logic sample_ready_n,
  input wire logic word_valid_o,
  input wire logic [23:0] word_data_o,
  input wire logic word_last_o,
  input wire logic word_ready_i
);
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);
  // divider, alert and stream checks
  a_mod_fall: assert property (mod_clk_o |=> !mod_clk_o)
    else $error("mod clk high twice");
  a_mod_rise: assert property (!mod_clk_o |=> mod_clk_o)
    else $error("mod clk low twice");
  a_ready_answer: assert property (
    conv_done_i && sample_ready_n |=> !sample_ready_n) else $error("no alert");
  a_valid_wait: assert property (
    conv_done_i && sample_ready_n |=> !word_valid_o ##1 word_valid_o)
    else $error("first word late");
  a_data_hold: assert property (
    word_valid_o && !word_ready_i |=>
    word_valid_o && $stable(word_data_o) && $stable(word_last_o))
    else $error("word dropped");
  a_valid_busy: assert property (
    word_valid_o |-> !sample_ready_n) else $error("valid while idle");
  a_ready_release: assert property (
    word_valid_o && word_ready_i && word_last_o && !conv_done_i
    |=> sample_ready_n)
    else $error("alert kept");
  a_ready_stays: assert property (
    !sample_ready_n && !(word_valid_o && word_ready_i && word_last_o)
    |=> !sample_ready_n) else $error("alert lost");
  // main scenarios
  c_frame: cover property (word_valid_o && word_ready_i && word_last_o);
  c_stall: cover property (word_valid_o && !word_ready_i);
  c_drop: cover property (conv_done_i && !sample_ready_n);
endmodule : mcasl_chk
bind mcasl_core mcasl_chk i_chk (.ref_clk_i, .reset_i, .conv_done_i,
  .mod_clk_o, .sample_ready_n, .word_valid_o, .word_data_o, .word_last_o,
  .word_ready_i);
`default_nettype wire

// File: verification/mcasl_host.sv
`timescale 1ns/100ps
`default_nettype none
module mcasl_host
(
  // clock, reset, pacing
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic slow_i,
  // stream from the converter
  input wire logic sample_ready_n,
  input wire logic word_valid_o,
  input wire logic [23:0] word_data_o,
  input wire logic word_last_o,
  output logic word_ready_i,
  // last frame seen
  output logic [23:0] got_q [5],
  output logic [2:0] nw_q
);
  logic tog_q;
  logic [2:0] idx_q;
  // fetch only after the alert, every other cycle when slow
  assign word_ready_i = !sample_ready_n && !(slow_i && tog_q);
  // store popped words and frame length
  always_ff @(posedge ref_clk_i or posedge reset_i)
    if (reset_i)
    begin
      tog_q <= 1'b0;
      idx_q <= 3'h0;
      nw_q <= 3'h0;
    end
    else
    begin
      tog_q <= !tog_q;
      if (word_valid_o && word_ready_i)
      begin
        got_q[idx_q] <= word_data_o;
        idx_q <= word_last_o ? 3'h0 : idx_q + 3'h1;
        if (word_last_o)
          nw_q <= idx_q + 3'h1;
      end
    end
endmodule : mcasl_host
`default_nettype wire

// File: verification/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb
  import mcasl_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic conv_done_i = 1'b0;
  logic [95:0] raw_samples_i = '0;
  logic cfg_we_i = 1'b0;
  logic [1:0] cfg_ch_i = 2'h0;
  logic [2:0] cfg_gain_i = 3'h0;
  logic [9:0] cfg_phase_i = 10'h000;
  logic [23:0] cfg_offset_i = 24'h000000;
  logic [23:0] cfg_gain_cal_i = 24'h800000;
  logic crc_in_en_i = 1'b0;
  logic crc_out_en_i = 1'b0;
  logic crc_map_en_i = 1'b0;
  logic [15:0] cfg_crc_i = 16'h0000;
  logic slow = 1'b0;
  logic mod_clk_o, cfg_crc_err_o, sample_ready_n, word_valid_o;
  logic word_last_o, word_ready_i;
  logic [15:0] map_crc_o;
  logic [11:0] gain_sel_o;
  logic [39:0] phase_o;
  logic [23:0] word_data_o, off0 = 24'h000000;
  logic [23:0] got [5];
  logic [2:0] nw;
  int fail_count = 0;
  int n_tests = 0;
  // rows: {second strobe, crc word, slow host, samples}
  logic [98:0] rows [4] = '{{3'h0, 96'h000004000003000002000001},
    {3'h2, 96'h00ABCD1234560000007FFFFF}, {3'h3, 96'h0F0F0F00FFFF0000FF000FFF},
    {3'h5, 96'h111111222222333333444444}};
  // bench drives the master clock, 5 ns period
  always #2.5 ref_clk_i = ~ref_clk_i;
  mcasl_core i_dut (.ref_clk_i, .reset_i, .conv_done_i, .raw_samples_i,
    .mod_clk_o, .cfg_we_i, .cfg_ch_i, .cfg_gain_i, .cfg_phase_i, .cfg_offset_i,
    .cfg_gain_cal_i, .crc_in_en_i, .crc_out_en_i, .crc_map_en_i, .cfg_crc_i,
    .cfg_crc_err_o, .map_crc_o, .gain_sel_o, .phase_o, .sample_ready_n,
    .word_valid_o, .word_data_o, .word_last_o, .word_ready_i);
  mcasl_host i_host (.ref_clk_i, .reset_i, .slow_i(slow), .sample_ready_n,
    .word_valid_o, .word_data_o, .word_last_o, .word_ready_i, .got_q(got),
    .nw_q(nw));
  // compare and count
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("tests=%0d fails=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize
  // ccitt crc, msb first
  function automatic logic [15:0] crc_w(input logic [15:0] c,
                                        input logic [23:0] w);
    for (int i = 23; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i]) ? MCASL_CRC_POLY : 16'h0000);
    return c;
  endfunction : crc_w
  task automatic cfg(input logic [1:0] ch, input logic [2:0] g,
                     input logic [23:0] off, input logic [15:0] cv);
    @(posedge ref_clk_i);
    cfg_we_i <= 1'b1;
    cfg_ch_i <= ch;
    cfg_gain_i <= g;
    cfg_phase_i <= {7'h00, g};
    cfg_offset_i <= off;
    cfg_crc_i <= cv;
    @(posedge ref_clk_i);
    cfg_we_i <= 1'b0;
    @(negedge ref_clk_i);
  endtask : cfg
  task automatic frame(input logic [98:0] row);
    int k;
    logic [15:0] c;
    logic [23:0] e;
    @(posedge ref_clk_i);
    crc_out_en_i <= row[97];
    slow <= row[96];
    conv_done_i <= 1'b1;
    raw_samples_i <= row[95:0];
    @(posedge ref_clk_i);
    conv_done_i <= 1'b0;
    if (row[98])
    begin
      @(posedge ref_clk_i);
      conv_done_i <= 1'b1;
      raw_samples_i <= ~row[95:0];
      @(posedge ref_clk_i);
      conv_done_i <= 1'b0;
    end
    for (k = 0; k < 40 && (k < 2 || !sample_ready_n); k++)
      @(negedge ref_clk_i);
    if (k == 40)
    begin
      fail_count++;
      summarize();
    end
    c = MCASL_CRC_SEED;
    chk(nw, row[97] ? 3'h5 : 3'h4);
    for (int i = 0; i < 4; i++)
    begin
      e = row[i*24+:24] + (i == 0 ? off0 : 24'h000000);
      chk(got[i], e);
      c = crc_w(c, e);
    end
    if (row[97])
      chk(got[4], {8'h00, c});
    repeat (3)
    begin
      @(negedge ref_clk_i);
      chk(sample_ready_n, 1'b1);
    end
  endtask : frame
  // main sequence
  initial
  begin
    logic [15:0] c;
    repeat (8) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    @(negedge ref_clk_i);
    chk(sample_ready_n, 1'b1);
    chk(gain_sel_o, 12'h000);
    chk(map_crc_o, 16'hFFFF);
    foreach (rows[r])
      frame(rows[r]);
    for (int j = 0; j < 8; j++)
    begin
      cfg(j[1:0], j[2:0], 24'h000000, 16'h0000);
      chk(gain_sel_o[j[1:0]*3+:3], j[2:0]);
      chk(phase_o[j[1:0]*10+:10], j[2:0]);
    end
    chk(gain_sel_o, 12'hFAC);
    c = crc_w(crc_w(MCASL_CRC_SEED, 24'h000010), MCASL_GAIN_CAL_ONE);
    crc_in_en_i <= 1'b1;
    cfg(2'h0, 3'h1, 24'h000010, ~c);
    chk({cfg_crc_err_o, gain_sel_o[2:0]}, 4'hC);
    cfg(2'h0, 3'h1, 24'h000010, c);
    chk({cfg_crc_err_o, gain_sel_o[2:0]}, 4'h1);
    crc_in_en_i <= 1'b0;
    crc_map_en_i <= 1'b1;
    repeat (2) @(negedge ref_clk_i);
    chk(map_crc_o == 16'hFFFF, 1'b0);
    crc_map_en_i <= 1'b0;
    @(negedge ref_clk_i);
    chk(map_crc_o, 16'hFFFF);
    off0 = 24'h000010;
    frame({3'h2, rows[0][95:0]});
    summarize();
  end
endmodule : tb
`default_nettype wire
